// file: rtl/rtipa_defines.svh
// Offsets, field positions, reset values and counts of the periodic interrupt and accumulator block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef RTIPA_DEFINES_SVH
`define RTIPA_DEFINES_SVH

// Register byte offsets
`define RTIPA_OFS_CTRL 6'h00
`define RTIPA_OFS_MASK 6'h04
`define RTIPA_OFS_FLAG 6'h08
`define RTIPA_OFS_COUNT 6'h0c
`define RTIPA_OFS_WDOG 6'h10
`define RTIPA_OFS_STAT 6'h14

// Control register fields
`define RTIPA_CTRL_RATE_LO 0
`define RTIPA_CTRL_RATE_HI 1
`define RTIPA_CTRL_MODE 4
`define RTIPA_CTRL_ENABLE 5
`define RTIPA_CTRL_EDGE 6

// Mask and flag fields, same layout in both
`define RTIPA_IRQ_PERIODIC 0
`define RTIPA_IRQ_OVF 1
`define RTIPA_IRQ_EDGE 2

// Watchdog configuration fields
`define RTIPA_WD_RATE_LO 0
`define RTIPA_WD_RATE_HI 1
`define RTIPA_WD_DISABLE 2

// Reset values
`define RTIPA_CTRL_RST 5'h00
`define RTIPA_MASK_RST 3'h0
`define RTIPA_WDOG_RST 3'h0

// Timing
`define RTIPA_BASE_LOG2 13
`define RTIPA_GATE_DIV 64
`define RTIPA_GATE_LOG2 6
`define RTIPA_WD_TAP 15
`define RTIPA_CHAIN_W 18

`endif

// file: rtl/rtipa_pkg.sv
// Types shared by the periodic interrupt and accumulator block.
// Assumes rtipa_defines.svh for numeric constants.
`default_nettype none
package rtipa_pkg;

  typedef struct packed {
    logic edge_rise;
    logic enable;
    logic mode_gated;
    logic [1:0] rate;
  } rtipa_ctrl_t;

  typedef struct packed {
    logic edge_ev;
    logic ovf;
    logic periodic;
  } rtipa_irq_t;

  typedef struct packed {
    logic disable_wd;
    logic [1:0] rate;
  } rtipa_wdog_t;

  typedef enum logic [1:0] {
    RTIPA_BUS_IDLE,
    RTIPA_BUS_ACK
  } rtipa_bus_t;

endpackage : rtipa_pkg
`default_nettype wire

// file: rtl/rtipa_top.sv
// Periodic interrupt timebase, 8-bit pulse accumulator and watchdog clock tap with an Avalon-MM register slave.
// Assumes a single 100 MHz clock; the accumulator pin is already synchronous to it.
`include "rtipa_defines.svh"
`default_nettype none

module rtipa_top
  import rtipa_pkg::*;
#(
  parameter int CHAIN_W = `RTIPA_CHAIN_W
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Accumulator pin
  input wire logic accum_input_pin_in,
  // Watchdog clock tap and interrupt
  output logic watchdog_tick_out,
  output logic irq_out
);

  if (CHAIN_W < `RTIPA_BASE_LOG2 + 3 || CHAIN_W < `RTIPA_WD_TAP + 3) begin : g_chain_check
    $error("CHAIN_W too small for the longest periodic or watchdog tap");
  end

  rtipa_ctrl_t ctrl;
  rtipa_irq_t mask;
  rtipa_irq_t flag;
  rtipa_wdog_t wdog;
  logic [7:0] count;
  logic [CHAIN_W-1:0] chain;
  logic [CHAIN_W-1:0] next_chain;
  logic pin_q;
  logic periodic_tick;
  logic gate_tick;
  logic wd_tick;
  logic pin_edge;
  logic acc_inc;
  logic ovf_ev;
  rtipa_bus_t bus_state;
  logic wr_ack;
  logic rd_ack;
  logic [31:0] rd_word;

  // Free-running divider chain; nothing but reset stops it
  assign next_chain = chain + {{(CHAIN_W-1){1'b0}}, 1'b1};

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  // A tap bit wraps to zero exactly at each 2^(13+rate) boundary, so the interval is fixed
  // by the chain and not by the flag clear; the first one lands a full interval after reset.
  always_comb begin
    periodic_tick = 1'b0;
    unique case (ctrl.rate)
      2'h0: periodic_tick = next_chain[`RTIPA_BASE_LOG2-1:0] == '0;
      2'h1: periodic_tick = next_chain[`RTIPA_BASE_LOG2:0] == '0;
      2'h2: periodic_tick = next_chain[`RTIPA_BASE_LOG2+1:0] == '0;
      2'h3: periodic_tick = next_chain[`RTIPA_BASE_LOG2+2:0] == '0;
    endcase
  end

  assign gate_tick = next_chain[`RTIPA_GATE_LOG2-1:0] == '0;

  // Watchdog clock: one of four taps off the chain, silent when disabled
  always_comb begin
    wd_tick = 1'b0;
    unique case (wdog.rate)
      2'h0: wd_tick = next_chain[`RTIPA_WD_TAP-1:0] == '0;
      2'h1: wd_tick = next_chain[`RTIPA_WD_TAP:0] == '0;
      2'h2: wd_tick = next_chain[`RTIPA_WD_TAP+1:0] == '0;
      2'h3: wd_tick = next_chain[`RTIPA_WD_TAP+2:0] == '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watchdog_tick_out <= 1'b0;
    end else begin
      watchdog_tick_out <= wd_tick && !wdog.disable_wd;
    end
  end

  // Pin edge detect; the source keeps events at or below half the clock rate
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= accum_input_pin_in;
    end
  end

  assign pin_edge = ctrl.edge_rise ? (accum_input_pin_in && !pin_q) : (!accum_input_pin_in && pin_q);

  // Active level in gated mode follows the edge polarity bit: high when rising is selected
  always_comb begin
    acc_inc = 1'b0;
    if (ctrl.enable) begin
      if (ctrl.mode_gated) begin
        acc_inc = gate_tick && (accum_input_pin_in == ctrl.edge_rise);
      end else begin
        acc_inc = pin_edge;
      end
    end
  end

  assign ovf_ev = acc_inc && count == 8'hff;

  logic cnt_wr;
  assign cnt_wr = wr_ack && avs_address_in == `RTIPA_OFS_COUNT && avs_byteenable_in[0];

  // A software write wins over a same-cycle increment
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 8'h00;
    end else if (cnt_wr) begin
      count <= avs_writedata_in[7:0];
    end else if (acc_inc) begin
      count <= count + 8'h01;
    end
  end

  // Bus slave: one wait cycle per access, answer on the second edge
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_state <= RTIPA_BUS_IDLE;
    end else begin
      unique case (bus_state)
        RTIPA_BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state <= RTIPA_BUS_ACK;
          end
        end
        RTIPA_BUS_ACK: bus_state <= RTIPA_BUS_IDLE;
        default: bus_state <= RTIPA_BUS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && bus_state != RTIPA_BUS_ACK;
  assign wr_ack = avs_write_in && bus_state == RTIPA_BUS_ACK;
  assign rd_ack = avs_read_in && bus_state == RTIPA_BUS_ACK;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl <= rtipa_ctrl_t'(`RTIPA_CTRL_RST);
      mask <= rtipa_irq_t'(`RTIPA_MASK_RST);
      wdog <= rtipa_wdog_t'(`RTIPA_WDOG_RST);
    end else if (wr_ack && avs_byteenable_in[0]) begin
      if (avs_address_in == `RTIPA_OFS_CTRL) begin
        ctrl.rate <= avs_writedata_in[`RTIPA_CTRL_RATE_HI:`RTIPA_CTRL_RATE_LO];
        ctrl.mode_gated <= avs_writedata_in[`RTIPA_CTRL_MODE];
        ctrl.enable <= avs_writedata_in[`RTIPA_CTRL_ENABLE];
        ctrl.edge_rise <= avs_writedata_in[`RTIPA_CTRL_EDGE];
      end
      if (avs_address_in == `RTIPA_OFS_MASK) begin
        mask <= avs_writedata_in[`RTIPA_IRQ_EDGE:`RTIPA_IRQ_PERIODIC];
      end
      if (avs_address_in == `RTIPA_OFS_WDOG) begin
        wdog <= avs_writedata_in[`RTIPA_WD_DISABLE:`RTIPA_WD_RATE_LO];
      end
    end
  end

  // Sticky flags: write one to clear, a new event in the same cycle wins
  rtipa_irq_t flag_set;
  rtipa_irq_t flag_clr;
  assign flag_set = '{edge_ev: acc_inc && !ctrl.mode_gated, ovf: ovf_ev, periodic: periodic_tick};
  assign flag_clr = (wr_ack && avs_byteenable_in[0] && avs_address_in == `RTIPA_OFS_FLAG)
                    ? rtipa_irq_t'(avs_writedata_in[`RTIPA_IRQ_EDGE:`RTIPA_IRQ_PERIODIC]) : '0;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((flag & ~flag_clr | flag_set) & mask);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address_in)
      `RTIPA_OFS_CTRL: rd_word[6:0] = {ctrl.edge_rise, ctrl.enable, ctrl.mode_gated, 2'h0, ctrl.rate};
      `RTIPA_OFS_MASK: rd_word[2:0] = mask;
      `RTIPA_OFS_FLAG: rd_word[2:0] = flag;
      `RTIPA_OFS_COUNT: rd_word[7:0] = count;
      `RTIPA_OFS_WDOG: rd_word[2:0] = wdog;
      `RTIPA_OFS_STAT: rd_word[0] = accum_input_pin_in;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && bus_state == RTIPA_BUS_IDLE) begin
      avs_readdata_out <= rd_word;
    end
  end

  // Assertions
  sequence s_per_hit;
    periodic_tick;
  endsequence

  property p_flag_after_tick;
    @(posedge sys_clk_in) disable iff (!arst_n_in) s_per_hit |=> flag.periodic;
  endproperty

  AST_PERIODIC_SETS_FLAG: assert property (p_flag_after_tick) else $error("periodic flag not set after timeout");

  AST_TICK_ON_BOUNDARY: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    periodic_tick |-> next_chain[12:0] == 13'h0000) else $error("periodic tick off the 2^13 grid");

  AST_RATE_SPACING: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    periodic_tick && ctrl.rate == 2'h3 |-> next_chain[15:0] == 16'h0000) else $error("rate 3 tick off grid");

  AST_CHAIN_RUNS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    1'b1 |=> chain == $past(chain) + {{(CHAIN_W-1){1'b0}}, 1'b1}) else $error("divider chain stalled");

  // The level is registered from the next flag value and the mask as it stood before the edge
  AST_IRQ_NEEDS_ENABLE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    irq_out == |(flag & $past(mask))) else $error("interrupt level disagrees with flags and mask");

  AST_NO_FLAG_EARLY: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    flag.periodic && !$past(flag.periodic) |-> $past(periodic_tick)) else $error("periodic flag without a timeout");

  AST_EVENT_COUNT: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    ctrl.enable && !ctrl.mode_gated && pin_edge && !cnt_wr |=> count == $past(count) + 8'h01)
    else $error("event not counted");

  AST_GATE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    ctrl.mode_gated && !gate_tick && !cnt_wr |=> count == $past(count)) else $error("gated count moved off tick");

  AST_WRAP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    acc_inc && count == 8'hff && !cnt_wr |=> count == 8'h00 && flag.ovf) else $error("counter did not wrap");

  AST_CNT_WRITE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    cnt_wr |=> count == $past(avs_writedata_in[7:0])) else $error("counter write lost");

  AST_WD_OFF: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    $past(wdog.disable_wd) |-> !watchdog_tick_out) else $error("watchdog ticks while disabled");

  // Bus handshake
  sequence s_bus_req;
    (avs_read_in || avs_write_in) && bus_state == RTIPA_BUS_IDLE;
  endsequence

  sequence s_bus_held;
    avs_read_in || avs_write_in;
  endsequence

  property p_one_wait_state;
    @(posedge sys_clk_in) disable iff (!arst_n_in) s_bus_req ##1 s_bus_held |-> !avs_waitrequest_out;
  endproperty

  AST_BUS_ONE_WAIT: assert property (p_one_wait_state) else $error("no answer after one wait state");

  AST_BUS_FIRST_WAIT: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    s_bus_req |-> avs_waitrequest_out) else $error("bus answered without a wait state");

  AST_RDATA_STANDS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    rd_ack |=> $stable(avs_readdata_out)) else $error("read data changed after the answer");

  // Periodic flag and spacing
  AST_PERIODIC_W1C: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    flag_clr.periodic && !periodic_tick |=> !flag.periodic) else $error("periodic flag not cleared");

  AST_FLAG_STICKY: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    flag.periodic && !flag_clr.periodic |=> flag.periodic) else $error("periodic flag dropped without a clear");

  sequence s_per_quiet;
    !periodic_tick [*8];
  endsequence

  property p_tick_spacing;
    @(posedge sys_clk_in) disable iff (!arst_n_in) s_per_hit |=> s_per_quiet;
  endproperty

  AST_TICK_SPACING: assert property (p_tick_spacing) else $error("periodic timeouts too close together");

  // Watchdog tap
  AST_WD_ON_TAP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    watchdog_tick_out |-> chain[`RTIPA_WD_TAP-1:0] == '0) else $error("watchdog tick off its tap");

  AST_WD_SLOWEST: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    watchdog_tick_out && $past(wdog.rate) == 2'h3 |-> chain[`RTIPA_WD_TAP+2:0] == '0)
    else $error("slowest watchdog tap off grid");

  // Accumulator
  sequence s_gate_quiet;
    !gate_tick [*8];
  endsequence

  AST_GATE_SPACING: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    gate_tick |=> s_gate_quiet) else $error("gated ticks too close together");

  AST_GATE_COUNT: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    ctrl.enable && ctrl.mode_gated && gate_tick && accum_input_pin_in == ctrl.edge_rise && !cnt_wr
    |=> count == $past(count) + 8'h01) else $error("gated tick not counted");

  AST_EDGE_FLAG: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    acc_inc && !ctrl.mode_gated |=> flag.edge_ev) else $error("counted edge did not set its flag");

  AST_HOLD_WHEN_OFF: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
    !ctrl.enable && !cnt_wr |=> count == $past(count)) else $error("counter moved while disabled");

endmodule : rtipa_top
`default_nettype wire

// file: testbench/rtipa_pin_model.sv
// Behavioural source for the accumulator pin: counted pulse bursts or a held gate level.
// Assumes commands come synchronous to sys_clk_in and a burst is not restarted while busy.
`default_nettype none
module rtipa_pin_model (
  // Clock
  input wire logic sys_clk_in,
  // Commands
  input wire logic start_in,
  input wire logic [7:0] pulses_in,
  input wire logic gate_in,
  // Pin and status
  output logic pin_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  logic [1:0] phase = 2'h0;
  // Two cycles high, two low: a quarter of the clock rate, well inside the counting limit
  always @(posedge sys_clk_in) begin
    if (start_in && left == 8'h00) begin
      left <= pulses_in;
      phase <= 2'h0;
    end else if (left != 8'h00) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) left <= left - 8'h01;
    end
  end
  assign busy_out = (left != 8'h00);
  assign pin_out = busy_out ? ~phase[1] : gate_in;
endmodule : rtipa_pin_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench: register accesses over Avalon-MM, accumulator and periodic timing.
// Assumes the block's own clock only; the pin model drives the accumulator input.
`include "rtipa_defines.svh"
`default_nettype none
module tb
  import rtipa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq, tick, irq, pin, busy;
  logic start = 1'b0, gate = 1'b0;
  logic [7:0] npulse = 8'h00;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  int n_fail = 0, samples_checked = 0, cyc = 0, n_tick = 0, c;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= arst_n ? cyc + 1 : 0;
  always @(posedge sys_clk) if (tick === 1'b1) n_tick <= n_tick + 1;

  rtipa_top dut_u (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .accum_input_pin_in(pin), .watchdog_tick_out(tick), .irq_out(irq));
  rtipa_pin_model pin_u (.sys_clk_in(sys_clk), .start_in(start), .pulses_in(npulse), .gate_in(gate),
    .pin_out(pin), .busy_out(busy));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) check(32'h0, 32'h1);
  endtask : bus

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    check(q & m, exp);
  endtask : rd_chk

  // Starts a burst at the next edge and returns a few cycles after the pin has gone idle
  task automatic pulses(input logic [7:0] n);
    start <= 1'b1;
    npulse <= n;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    for (c = 0; c < 100 && busy !== 1'b0; c++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : pulses

  task automatic wait_irq(input int exp);
    int n;
    for (n = 0; n < 70000 && irq !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check(cyc, exp);
  endtask : wait_irq

  // Moving to a slower rate right after a timeout: the next one lands on the chain's next wrap
  task automatic next_rate(input logic [1:0] r, input int exp);
    bus(1'b1, `RTIPA_OFS_FLAG, 32'h1);
    bus(1'b1, `RTIPA_OFS_CTRL, {30'h0, r});
    wait_irq(exp);
  endtask : next_rate

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  initial begin
    #900000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(`RTIPA_OFS_COUNT, 32'h0, 32'hff);
    bus(1'b1, `RTIPA_OFS_WDOG, 32'h4);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h60);
    bus(1'b1, `RTIPA_OFS_MASK, 32'h2);
    bus(1'b1, `RTIPA_OFS_COUNT, 32'hfd);
    pulses(8'h04);
    rd_chk(`RTIPA_OFS_COUNT, 32'h01, 32'hff);
    rd_chk(`RTIPA_OFS_FLAG, 32'h6, 32'h6);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `RTIPA_OFS_FLAG, 32'h6);
    @(posedge sys_clk);
    #1;
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h20);
    pulses(8'h02);
    rd_chk(`RTIPA_OFS_COUNT, 32'h03, 32'hff);
    bus(1'b1, `RTIPA_OFS_COUNT, 32'h0);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h70);
    gate <= 1'b1;
    // Any 320 contiguous cycles hold exactly five divide-by-64 ticks
    repeat (320) @(posedge sys_clk);
    gate <= 1'b0;
    repeat (200) @(posedge sys_clk);
    rd_chk(`RTIPA_OFS_COUNT, 32'h05, 32'hff);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h30);
    // Idle pin is low, so active; 317 waits and the three edges of the next write make 320 cycles
    repeat (317) @(posedge sys_clk);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h0);
    rd_chk(`RTIPA_OFS_COUNT, 32'h0a, 32'hff);
    bus(1'b1, `RTIPA_OFS_FLAG, 32'h7);
    bus(1'b1, `RTIPA_OFS_MASK, 32'h1);
    wait_irq(8192);
    next_rate(2'h1, 16384);
    check(n_tick, 0);
    bus(1'b1, `RTIPA_OFS_WDOG, 32'h0);
    next_rate(2'h2, 32768);
    next_rate(2'h3, 65536);
    check(n_tick, 1);
    bus(1'b1, `RTIPA_OFS_MASK, 32'h0);
    bus(1'b1, `RTIPA_OFS_FLAG, 32'h1);
    bus(1'b1, `RTIPA_OFS_CTRL, 32'h0);
    repeat (8300) @(posedge sys_clk);
    #1;
    check({31'h0, irq}, 32'h0);
    rd_chk(`RTIPA_OFS_FLAG, 32'h1, 32'h1);
    finish_test();
  end
endmodule : tb
`default_nettype wire
